//--- adc_trim_bank.sv
// Calibration value bank with AXI4-Lite register access
`include "adc_trim_consts.svh"

module adc_trim_bank (
   input  wire logic                        clk,
   input  wire logic                        rst_n,
   // AXI4-Lite write address
   input  wire logic                        s_axi_awvalid,
   output      logic                        s_axi_awready,
   input  wire logic [`TRIM_ADDR_W-1:0]     s_axi_awaddr,
   input  wire logic [2:0]                  s_axi_awprot,
   // AXI4-Lite write data
   input  wire logic                        s_axi_wvalid,
   output      logic                        s_axi_wready,
   input  wire logic [31:0]                 s_axi_wdata,
   input  wire logic [3:0]                  s_axi_wstrb,
   // AXI4-Lite write response
   output      logic                        s_axi_bvalid,
   input  wire logic                        s_axi_bready,
   output      logic [1:0]                  s_axi_bresp,
   // AXI4-Lite read address
   input  wire logic                        s_axi_arvalid,
   output      logic                        s_axi_arready,
   input  wire logic [`TRIM_ADDR_W-1:0]     s_axi_araddr,
   input  wire logic [2:0]                  s_axi_arprot,
   // AXI4-Lite read data
   output      logic                        s_axi_rvalid,
   input  wire logic                        s_axi_rready,
   output      logic [31:0]                 s_axi_rdata,
   output      logic [1:0]                  s_axi_rresp,
   // Calibration engine side
   input  wire logic                        cal_run,
   input  wire logic [6:0][`TRIM_MAX_W-1:0] cal_plus_vals,
   input  wire logic [6:0][`TRIM_MAX_W-1:0] cal_minus_vals,
   // Stored values toward the converter
   output      logic [6:0][`TRIM_MAX_W-1:0] trim_plus,
   output      logic [6:0][`TRIM_MAX_W-1:0] trim_minus
);

   // Entry order: plus D,S,4,3,2,1,0 then minus D,S,4,3,2,1,0
   localparam logic [`TRIM_ADDR_W-1:0] OFS_TAB [`TRIM_NUM] = '{
      `OFS_PLUS_D, `OFS_PLUS_S, `OFS_PLUS_4, `OFS_PLUS_3,
      `OFS_PLUS_2, `OFS_PLUS_1, `OFS_PLUS_0,
      `OFS_MINUS_D, `OFS_MINUS_S, `OFS_MINUS_4, `OFS_MINUS_3,
      `OFS_MINUS_2, `OFS_MINUS_1, `OFS_MINUS_0
   };
   localparam int unsigned FW_TAB [`TRIM_NUM] = '{
      `TRIM_W_D, `TRIM_W_S, `TRIM_W_4, `TRIM_W_3, `TRIM_W_2, `TRIM_W_1, `TRIM_W_0,
      `TRIM_W_D, `TRIM_W_S, `TRIM_W_4, `TRIM_W_3, `TRIM_W_2, `TRIM_W_1, `TRIM_W_0
   };

   adc_trim_pkg::bank_state_t                 state_ff;
   adc_trim_pkg::bank_state_t                 nxt_state;
   logic [`TRIM_NUM-1:0][`TRIM_MAX_W-1:0]     cal_all;
   logic [`TRIM_NUM-1:0][`TRIM_MAX_W-1:0]     trim_all;
   logic [`TRIM_NUM-1:0]                      wr_hit;
   logic [`TRIM_MAX_W-1:0]                    wr_lane_mask;
   logic [`TRIM_NUM-1:0][`TRIM_MAX_W-1:0]     wr_merged;
   logic                                      hw_load;
   logic                                      do_write;
   logic                                      wr_status;
   logic                                      wr_mapped;
   logic                                      rd_take;

   // Generated values in entry order
   assign cal_all = {cal_minus_vals, cal_plus_vals};

   // Run flag falling marks the end of calibration
   assign hw_load = state_ff.cal_run_prev && !cal_run;

   // Write executes once address and data are both held
   assign do_write     = state_ff.aw_held && state_ff.w_held && !state_ff.bvalid;
   assign wr_lane_mask = {{2{state_ff.wstrb[1]}}, {8{state_ff.wstrb[0]}}};
   assign wr_status    = state_ff.awaddr[`TRIM_ADDR_W-1:2] == `OFS_STATUS >> 2;
   assign wr_mapped    = (|wr_hit) || wr_status;

   // One decoder, one merge and one register per entry
   genvar gi;
   generate
      for (gi = 0; gi < `TRIM_NUM; gi++) begin : g_trim
         assign wr_hit[gi] = do_write &&
            (state_ff.awaddr[`TRIM_ADDR_W-1:2] == OFS_TAB[gi][`TRIM_ADDR_W-1:2]);
         assign wr_merged[gi] = (trim_all[gi] & ~wr_lane_mask) |
                                (state_ff.wdata[`TRIM_MAX_W-1:0] & wr_lane_mask);
         trim_reg #(
            .W (FW_TAB[gi])
         ) u_trim_reg (
            .clk     (clk),
            .rst_n   (rst_n),
            .hw_load (hw_load),
            .hw_val  (cal_all[gi]),
            .sw_wr   (wr_hit[gi]),
            .sw_val  (wr_merged[gi]),
            .value   (trim_all[gi])
         );
      end
   endgenerate

   // Read decode: stored field zero-extended, unmapped gives an error
   function automatic logic [33:0] read_word(input logic [`TRIM_ADDR_W-1:0] addr,
                                             input logic [`TRIM_NUM-1:0][`TRIM_MAX_W-1:0] vals,
                                             input logic run,
                                             input logic loaded);
      logic [33:0] res;
      res = {`RESP_SLVERR, `DATA_RST};
      for (int i = 0; i < `TRIM_NUM; i++) begin
         if (addr[`TRIM_ADDR_W-1:2] == OFS_TAB[i][`TRIM_ADDR_W-1:2]) begin
            res = {`RESP_OKAY, 22'h000000, vals[i]};
         end
      end
      if (addr[`TRIM_ADDR_W-1:2] == `OFS_STATUS >> 2) begin
         res = {`RESP_OKAY, 30'h00000000, loaded, run};
      end
      return res;
   endfunction

   // Bus handshakes: each write half accepts while not held and no response is pending; reads while no read data is pending
   assign s_axi_awready = !state_ff.aw_held && !state_ff.bvalid;
   assign s_axi_wready  = !state_ff.w_held && !state_ff.bvalid;
   assign s_axi_arready = !state_ff.rvalid;
   assign rd_take       = s_axi_arvalid && s_axi_arready;

   // Next state of the slave and the bank control
   always_comb begin
      nxt_state = state_ff;
      nxt_state.cal_run_prev = cal_run;
      // Capture write address and data in either order
      if (s_axi_awvalid && s_axi_awready) begin
         nxt_state.aw_held = 1'b1;
         nxt_state.awaddr  = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         nxt_state.w_held = 1'b1;
         nxt_state.wdata  = s_axi_wdata;
         nxt_state.wstrb  = s_axi_wstrb;
      end
      // Complete the write and raise its response
      if (do_write) begin
         nxt_state.aw_held = 1'b0;
         nxt_state.w_held  = 1'b0;
         nxt_state.bvalid  = 1'b1;
         nxt_state.bresp   = wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (state_ff.bvalid && s_axi_bready) begin
         nxt_state.bvalid = 1'b0;
      end
      // Loaded flag: write one clears, a calibration load wins
      if (do_write && wr_status && state_ff.wstrb[0] &&
          state_ff.wdata[`STAT_LOADED_BIT]) begin
         nxt_state.loaded = 1'b0;
      end
      if (hw_load) begin
         nxt_state.loaded = 1'b1;
      end
      // Read: data registered one cycle after the address is taken
      if (state_ff.rvalid && s_axi_rready) begin
         nxt_state.rvalid = 1'b0;
      end
      if (rd_take) begin
         nxt_state.rvalid = 1'b1;
         {nxt_state.rresp, nxt_state.rdata} =
            read_word(s_axi_araddr, trim_all, cal_run, state_ff.loaded);
      end
   end

   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff.aw_held      <= 1'b0;
         state_ff.awaddr       <= `TRIM_ADDR_W'(0);
         state_ff.w_held       <= 1'b0;
         state_ff.wdata        <= `DATA_RST;
         state_ff.wstrb        <= 4'h0;
         state_ff.bvalid       <= 1'b0;
         state_ff.bresp        <= `RESP_OKAY;
         state_ff.rvalid       <= 1'b0;
         state_ff.rdata        <= `DATA_RST;
         state_ff.rresp        <= `RESP_OKAY;
         state_ff.cal_run_prev <= 1'b0;
         state_ff.loaded       <= 1'b0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Outputs
   assign s_axi_bvalid = state_ff.bvalid;
   assign s_axi_bresp  = state_ff.bresp;
   assign s_axi_rvalid = state_ff.rvalid;
   assign s_axi_rdata  = state_ff.rdata;
   assign s_axi_rresp  = state_ff.rresp;
   assign trim_plus    = trim_all[6:0];
   assign trim_minus   = trim_all[13:7];

   // End of calibration sets the loaded flag and loads both D entries on the next edge
   sequence s_cal_end;
      $fell(cal_run);
   endsequence
   sequence s_loaded_seen;
      ##1 (state_ff.loaded && trim_all[0] == ($past(cal_all[0]) & 10'h03F) &&
           trim_all[7] == ($past(cal_all[7]) & 10'h03F));
   endsequence
   property p_cal_load;
      @(posedge clk) disable iff (!rst_n)
         s_cal_end |-> s_loaded_seen;
   endproperty
   a_cal_load: assert property (p_cal_load) else $error("calibration end not loaded");

   // Minus-side entry 1 takes its generated value
   property p_minus_load;
      @(posedge clk) disable iff (!rst_n)
         $fell(cal_run) |=> trim_minus[5] == ($past(cal_minus_vals[5]) & 10'h07F);
   endproperty
   a_minus_load: assert property (p_minus_load) else $error("minus value not loaded");

   // Plus-side S takes its generated value, cut to six bits
   property p_plus_s_load;
      @(posedge clk) disable iff (!rst_n)
         $fell(cal_run) |=> trim_plus[1] == ($past(cal_plus_vals[1]) & 10'h03F);
   endproperty
   a_plus_s_load: assert property (p_plus_s_load) else $error("plus value not loaded");

   // Write completes one cycle after both halves are held
   sequence s_wr_both;
      state_ff.aw_held && state_ff.w_held && !state_ff.bvalid;
   endsequence
   property p_wr_resp;
      @(posedge clk) disable iff (!rst_n)
         s_wr_both |=> s_axi_bvalid ##0 !state_ff.aw_held ##0 !state_ff.w_held;
   endproperty
   a_wr_resp: assert property (p_wr_resp) else $error("write response late");

   // No new write half is taken while a response is pending
   property p_wr_blocked;
      @(posedge clk) disable iff (!rst_n)
         s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_wr_blocked: assert property (p_wr_blocked) else $error("write taken while busy");

   // A write outside the bank is answered with an error
   property p_wr_refused;
      @(posedge clk) disable iff (!rst_n)
         (do_write && !wr_mapped) |=> s_axi_bresp == `RESP_SLVERR;
   endproperty
   a_wr_refused: assert property (p_wr_refused) else $error("unmapped write accepted");

   // Responses stand until taken
   property p_resp_hold;
      @(posedge clk) disable iff (!rst_n)
         (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_resp_hold: assert property (p_resp_hold) else $error("response dropped");

   // Read data stands until taken
   property p_rd_hold;
      @(posedge clk) disable iff (!rst_n)
         (s_axi_rvalid && !s_axi_rready) |=>
            s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");

   // Reads of plus-side 4 return the zero-extended field
   property p_read_plus4;
      @(posedge clk) disable iff (!rst_n)
         (rd_take && s_axi_araddr == `OFS_PLUS_4 && !hw_load && !(|wr_hit)) |=>
            s_axi_rvalid && s_axi_rdata == {22'h000000, trim_all[2]};
   endproperty
   a_read_plus4: assert property (p_read_plus4) else $error("plus read wrong");

   // Minus-side S decodes at its offset
   property p_read_minus_s;
      @(posedge clk) disable iff (!rst_n)
         (rd_take && s_axi_araddr == `OFS_MINUS_S) |=>
            s_axi_rresp == `RESP_OKAY && s_axi_rdata[31:6] == 26'h0000000;
   endproperty
   a_read_minus_s: assert property (p_read_minus_s) else $error("minus read wrong");

   // Read data never shows bits above the widest field
   property p_rd_upper;
      @(posedge clk) disable iff (!rst_n)
         s_axi_rvalid |-> s_axi_rdata[31:`TRIM_MAX_W] == 22'h000000;
   endproperty
   a_rd_upper: assert property (p_rd_upper) else $error("reserved bits read set");

   // Load beats a same-cycle write of plus-side 4
   property p_load_wins;
      @(posedge clk) disable iff (!rst_n)
         (hw_load && wr_hit[2]) |=> trim_all[2] == ($past(cal_all[2]) & 10'h3FF);
   endproperty
   a_load_wins: assert property (p_load_wins) else $error("write beat calibration load");

   // Width of widest plus-side entry is ten bits
   property p_plus4_width;
      @(posedge clk) disable iff (!rst_n)
         $fell(cal_run) |=> trim_plus[2] == $past(cal_plus_vals[2]);
   endproperty
   a_plus4_width: assert property (p_plus4_width) else $error("ten-bit field truncated");

endmodule

//--- adc_trim_consts.svh
// Offsets, field widths, reset values and bus codes of the calibration value bank
`ifndef ADC_TRIM_CONSTS_SVH
`define ADC_TRIM_CONSTS_SVH

// Address decode width within the module window
`define TRIM_ADDR_W      8
// Number of stored values and widest field
`define TRIM_NUM         14
`define TRIM_MAX_W       10

// Plus-side register offsets
`define OFS_PLUS_D       8'h34
`define OFS_PLUS_S       8'h38
`define OFS_PLUS_4       8'h3C
`define OFS_PLUS_3       8'h40
`define OFS_PLUS_2       8'h44
`define OFS_PLUS_1       8'h48
`define OFS_PLUS_0       8'h4C

// Minus-side register offsets
`define OFS_MINUS_D      8'h54
`define OFS_MINUS_S      8'h58
`define OFS_MINUS_4      8'h5C
`define OFS_MINUS_3      8'h60
`define OFS_MINUS_2      8'h64
`define OFS_MINUS_1      8'h68
`define OFS_MINUS_0      8'h6C

// Bank status register
`define OFS_STATUS       8'h70
`define STAT_RUN_BIT     0
`define STAT_LOADED_BIT  1

// Field widths of the seven values on each side
`define TRIM_W_D         6
`define TRIM_W_S         6
`define TRIM_W_4         10
`define TRIM_W_3         9
`define TRIM_W_2         8
`define TRIM_W_1         7
`define TRIM_W_0         6

// Reset values
`define TRIM_RST         10'h000
`define DATA_RST         32'h0000_0000

// Bus response codes
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

//--- adc_trim_pkg.sv
// State types of the calibration value bank
package adc_trim_pkg;
`include "adc_trim_consts.svh"

   // State of one stored calibration value
   typedef struct packed {
      logic [`TRIM_MAX_W-1:0] val;
   } trim_state_t;

   // State of the bus slave and the bank control
   typedef struct packed {
      logic                    aw_held;
      logic [`TRIM_ADDR_W-1:0] awaddr;
      logic                    w_held;
      logic [31:0]             wdata;
      logic [3:0]              wstrb;
      logic                    bvalid;
      logic [1:0]              bresp;
      logic                    rvalid;
      logic [31:0]             rdata;
      logic [1:0]              rresp;
      logic                    cal_run_prev;
      logic                    loaded;
   } bank_state_t;

endpackage

//--- trim_reg.sv
// One calibration value register with hardware load priority
`include "adc_trim_consts.svh"

module trim_reg #(
   parameter int unsigned W = 6
) (
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   input  wire logic                   hw_load,
   input  wire logic [`TRIM_MAX_W-1:0] hw_val,
   input  wire logic                   sw_wr,
   input  wire logic [`TRIM_MAX_W-1:0] sw_val,
   output      logic [`TRIM_MAX_W-1:0] value
);

   localparam logic [`TRIM_MAX_W-1:0] FIELD_MASK = `TRIM_MAX_W'((1 << W) - 1);

   adc_trim_pkg::trim_state_t state_ff;
   adc_trim_pkg::trim_state_t nxt_state;

   // Calibration load beats a software write in the same cycle
   always_comb begin
      nxt_state = state_ff;
      if (hw_load) begin
         nxt_state.val = hw_val;
      end else if (sw_wr) begin
         nxt_state.val = sw_val;
      end
      nxt_state.val = nxt_state.val & FIELD_MASK;
   end

   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff.val <= `TRIM_RST;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign value = state_ff.val;

   // Hardware load lands one cycle later, whatever software does
   property p_hw_load;
      @(posedge clk) disable iff (!rst_n)
         hw_load |=> value == ($past(hw_val) & FIELD_MASK);
   endproperty
   a_hw_load: assert property (p_hw_load) else $error("calibration load lost");

   // Software write lands when no load competes
   property p_sw_write;
      @(posedge clk) disable iff (!rst_n)
         (sw_wr && !hw_load) |=> value == ($past(sw_val) & FIELD_MASK);
   endproperty
   a_sw_write: assert property (p_sw_write) else $error("software write lost");

   // Value holds without a load or a write
   property p_hold;
      @(posedge clk) disable iff (!rst_n)
         (!sw_wr && !hw_load) |=> $stable(value);
   endproperty
   a_hold: assert property (p_hold) else $error("value changed unprompted");

   // Bits above the field are always zero
   property p_upper_zero;
      @(posedge clk) disable iff (!rst_n)
         (value & ~FIELD_MASK) == `TRIM_RST;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("bits above field set");

endmodule

//--- adc_trim_bank_test.sv
// Self-checking testbench of the calibration value bank
`include "adc_trim_consts.svh"

module adc_trim_bank_test;
   timeunit 1ns;
   timeprecision 100ps;

   // Field widths in register order D, S, 4, 3, 2, 1, 0
   localparam int W_TAB [7] = '{6, 6, 10, 9, 8, 7, 6};

   logic                        clk = 1'b0;
   logic                        rst_n = 1'b0;
   logic                        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic [7:0]                  s_axi_awaddr, s_axi_araddr;
   logic [31:0]                 s_axi_wdata, s_axi_rdata;
   logic [3:0]                  s_axi_wstrb;
   logic                        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic                        s_axi_rvalid, s_axi_rready;
   logic [1:0]                  s_axi_bresp, s_axi_rresp;
   logic                        cal_run;
   logic [6:0][9:0]             cal_plus_vals, cal_minus_vals, trim_plus, trim_minus;
   logic [6:0][9:0]             exp_plus, exp_minus;
   int                          n_mismatch = 0;
   int                          samples_checked = 0;
   int                          ready_lag = 0;

   // Clock of 4 ns period
   always #2 clk = ~clk;

   adc_trim_bank i_adc_trim_bank (
      .clk(clk), .rst_n(rst_n),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .cal_run(cal_run), .cal_plus_vals(cal_plus_vals), .cal_minus_vals(cal_minus_vals),
      .trim_plus(trim_plus), .trim_minus(trim_minus)
   );

   // Field mask, byte address and load pattern of one value
   function automatic logic [9:0] fmask(input int i);
      return 10'((32'h1 << W_TAB[i]) - 32'h1);
   endfunction
   function automatic logic [7:0] addr(input int side, input int i);
      return 8'((side == 0 ? 32'h34 : 32'h54) + 4 * i);
   endfunction
   function automatic logic [9:0] pat(input int i, input int side, input int run_no);
      return 10'(32'h2A5 + i * 123 + side * 273 + run_no * 59);
   endfunction

   // Verdict and end of run
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Compare tasks, one per kind of result
   task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t ns: read data %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t ns: response %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic check_trim(input logic [9:0] got, input logic [9:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t ns: stored value %h, expected %h", $time, got, exp);
      end
   endtask

   // Bus write: address and data offered together, released each when taken
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                            output logic [1:0] r);
      logic aw_ok, w_ok, b_ok;
      int   n;
      n = 0;
      b_ok = 1'b0;
      r = 2'h3;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= (ready_lag == 0);
      while (!b_ok && n < 100) begin
         @(negedge clk);
         aw_ok = s_axi_awvalid && s_axi_awready;
         w_ok = s_axi_wvalid && s_axi_wready;
         b_ok = s_axi_bvalid && s_axi_bready;
         r = s_axi_bresp;
         @(posedge clk);
         if (aw_ok) s_axi_awvalid <= 1'b0;
         if (w_ok) s_axi_wvalid <= 1'b0;
         if (n + 1 == ready_lag) s_axi_bready <= 1'b1;
         n++;
      end
      s_axi_bready <= 1'b0;
      if (!b_ok) begin
         n_mismatch++;
         $display("Error at %0t ns: write not answered", $time);
      end
   endtask

   // Bus read: address held until taken, data taken at the negedge where rvalid and rready are both high
   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ar_ok, r_ok;
      int   n;
      n = 0;
      r_ok = 1'b0;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= (ready_lag == 0);
      while (!r_ok && n < 100) begin
         @(negedge clk);
         ar_ok = s_axi_arvalid && s_axi_arready;
         r_ok = s_axi_rvalid && s_axi_rready;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge clk);
         if (ar_ok) s_axi_arvalid <= 1'b0;
         if (n + 1 == ready_lag) s_axi_rready <= 1'b1;
         n++;
      end
      s_axi_rready <= 1'b0;
      if (!r_ok) begin
         n_mismatch++;
         $display("Error at %0t ns: read not answered", $time);
      end
   endtask

   // Reads all fourteen registers and compares them and the stored outputs
   task automatic check_bank();
      logic [31:0] d;
      logic [1:0]  r;
      for (int i = 0; i < 14; i++) begin
         axi_read(addr(i / 7, i % 7), d, r);
         check_data(d, {22'h0, (i < 7 ? exp_plus[i % 7] : exp_minus[i % 7])});
         check_resp(r, `RESP_OKAY);
      end
      for (int i = 0; i < 7; i++) begin
         check_trim(trim_plus[i], exp_plus[i]);
         check_trim(trim_minus[i], exp_minus[i]);
      end
   endtask

   // Sets the generated values for a load and their expected stored form
   task automatic set_vals(input int run_no);
      for (int i = 0; i < 7; i++) begin
         cal_plus_vals[i] <= pat(i, 0, run_no);
         cal_minus_vals[i] <= pat(i, 1, run_no);
         exp_plus[i] = pat(i, 0, run_no) & fmask(i);
         exp_minus[i] = pat(i, 1, run_no) & fmask(i);
      end
   endtask

   // All values clear after reset
   task automatic t_reset();
      exp_plus = '0;
      exp_minus = '0;
      check_bank();
   endtask

   // End of calibration loads both sides
   task automatic t_cal_load(input int run_no);
      logic [31:0] d;
      logic [1:0]  r;
      @(posedge clk);
      set_vals(run_no);
      cal_run <= 1'b1;
      axi_read(`OFS_STATUS, d, r);
      check_data({31'h0, d[`STAT_RUN_BIT]}, 32'h1);
      cal_run <= 1'b0;
      repeat (2) @(posedge clk);
      check_bank();
      axi_read(`OFS_STATUS, d, r);
      check_data(d, 32'h1 << `STAT_LOADED_BIT);
      axi_write(`OFS_STATUS, 32'h1 << `STAT_LOADED_BIT, 4'h1, r);
      check_resp(r, `RESP_OKAY);
      axi_read(`OFS_STATUS, d, r);
      check_data(d, 32'h0);
   endtask

   // Software writes replace values; upper bits stay zero; lane 0 alone
   task automatic t_sw_write();
      logic [1:0] r;
      for (int i = 0; i < 14; i++) begin
         axi_write(addr(i / 7, i % 7), 32'hFFFF_FFFF, 4'hF, r);
         check_resp(r, `RESP_OKAY);
         axi_write(addr(i / 7, i % 7), 32'h0000_0000, 4'h1, r);
         check_resp(r, `RESP_OKAY);
         if (i < 7) exp_plus[i] = fmask(i) & 10'h300;
         else exp_minus[i - 7] = fmask(i - 7) & 10'h300;
      end
      check_bank();
   endtask

   // Addresses outside the bank are refused and change nothing
   task automatic t_unmapped();
      logic [7:0]  bad [3] = '{8'h00, 8'h30, 8'h74};
      logic [31:0] d;
      logic [1:0]  r;
      ready_lag = 3;
      foreach (bad[k]) begin
         axi_write(bad[k], 32'hFFFF_FFFF, 4'hF, r);
         check_resp(r, `RESP_SLVERR);
         axi_read(bad[k], d, r);
         check_data(d, 32'h0);
         check_resp(r, `RESP_SLVERR);
      end
      ready_lag = 0;
      check_bank();
   endtask

   // A load on the same edge as a write to plus_trim_4 wins
   task automatic t_load_beats_write();
      logic [1:0] r;
      int         n;
      @(posedge clk);
      set_vals(3);
      cal_run <= 1'b1;
      fork
         axi_write(8'h3C, 32'h0000_0000, 4'hF, r);
         begin
            n = 0;
            do begin
               @(posedge clk);
               n++;
            end while (!(s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready)
                       && n < 50);
            cal_run <= 1'b0;
         end
      join
      check_resp(r, `RESP_OKAY);
      check_bank();
   endtask

   // Main sequence
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      cal_run = 1'b0;
      cal_plus_vals = '0;
      cal_minus_vals = '0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_cal_load(1);
      t_sw_write();
      t_unmapped();
      t_load_beats_write();
      t_cal_load(2);
      finish_test();
   end

   // Watchdog against a hung handshake
   initial begin
      #100000;
      n_mismatch++;
      $display("Error at %0t ns: run did not complete", $time);
      finish_test();
   end
endmodule
